// *** src/mlc_regs.sv ***
// register bank: monitor-four lookup, identity, sample rate, configuration
// assumes a serial front end on the same clock handing one-cycle requests
`timescale 1ns/100ps
`include "mlc_regs_params.svh"

module mlc_regs
  import mlc_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5A,  // arbitrary value
  parameter logic [7:0] VERSION_VALUE  = 8'h01,  // arbitrary value
  parameter int         SUPPLY_LOW_BIT = 0,
  parameter int         LUT_DEPTH      = 32
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire mlc_req_s   req,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       password_level_two,
  input  wire logic       fourth_monitor_input_output_auto_enable,
  input  wire logic       double_table_mode,
  input  wire logic       upper_table_select,
  input  wire logic       conversion_done,
  input  wire logic [15:0] fourth_monitor_input,
  input  wire logic       supply_meas_done,
  input  wire logic       supply_above_low,
  input  wire mlc_alarm_s alarms,
  input  wire logic       burst_enable_input,
  input  wire logic       tx_disable_input,
  output logic      [7:0] fourth_monitor_input_driven_output,
  output logic            apc_sample_strobe,
  output logic            shutdown_gate_output,
  output logic            tx_fault_output,
  output logic      [7:0] slave_address
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] clamp_code(input logic [3:0] code);
    clamp_code = (code > `MLC_SAMPLE_MAX) ? `MLC_SAMPLE_MAX : code;
  endfunction : clamp_code

  function automatic logic [10:0] ns_cycles(input logic [31:0] ns);
    ns_cycles = 11'((ns + `MLC_CLOCK_PERIOD_NS - 1) / `MLC_CLOCK_PERIOD_NS);
  endfunction : ns_cycles

  function automatic logic [10:0] first_cycles(input logic [3:0] code);
    logic [9:0][31:0] tbl;
    tbl          = `MLC_FIRST_NS;
    first_cycles = ns_cycles(tbl[clamp_code(code)]);
  endfunction : first_cycles

  function automatic logic [10:0] rep_cycles(input logic [3:0] code);
    logic [9:0][31:0] tbl;
    tbl        = `MLC_REP_NS;
    rep_cycles = ns_cycles(tbl[clamp_code(code)]);
  endfunction : rep_cycles

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] alarm_meta;
  logic [7:0] alarm_sync;
  logic       burst_meta;
  logic       burst_sync;
  logic       txd_meta;
  logic       txd_sync;
  logic       txd_prev;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      alarm_meta <= 8'h00;
      alarm_sync <= 8'h00;
      burst_meta <= 1'b0;
      burst_sync <= 1'b0;
      txd_meta   <= 1'b0;
      txd_sync   <= 1'b0;
      txd_prev   <= 1'b0;
    end else begin
      alarm_meta <= alarms.state;
      alarm_sync <= alarm_meta;
      burst_meta <= burst_enable_input;
      burst_sync <= burst_meta;
      txd_meta   <= tx_disable_input;
      txd_sync   <= txd_meta;
      txd_prev   <= txd_sync;
    end
  end

  // ----------------------------------------------------------------------
  // register storage and access decode
  // ----------------------------------------------------------------------
  logic [7:0] lut [LUT_DEPTH];
  logic [3:0] sample_period_code;
  logic [7:0] config_byte;
  logic [7:0] device_address;
  logic       main_hit;
  logic       lut_hit;
  logic       wr_ok;

  assign main_hit = (req.table_sel == `MLC_TABLE_MAIN);
  assign lut_hit  = (req.table_sel == `MLC_TABLE_LUT) && (req.addr[7:5] == `MLC_LUT_BASE);
  assign wr_ok    = req.wr && password_level_two;

  always_ff @(posedge clock) begin
    if (lut_hit && wr_ok) begin
      lut[req.addr[4:0]] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sample_period_code <= `MLC_RST_SAMPLE;
      config_byte        <= `MLC_RST_CONFIG;
      device_address     <= `MLC_RST_DEV_ADDR;
    end else if (main_hit && wr_ok) begin
      case (req.addr)
        `MLC_OFF_SAMPLE:   sample_period_code <= req.wdata[3:0];
        `MLC_OFF_CONFIG: begin
          config_byte <= 8'h00;
          config_byte[`MLC_CFG_POLARITY] <= req.wdata[`MLC_CFG_POLARITY];
          config_byte[`MLC_CFG_LATCH]    <= req.wdata[`MLC_CFG_LATCH];
          config_byte[`MLC_CFG_ADDRESS_SELECT]     <= req.wdata[`MLC_CFG_ADDRESS_SELECT];
        end
        `MLC_OFF_DEV_ADDR: device_address <= req.wdata;
        default:           device_address <= device_address;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // lookup address and monitor-four output
  // ----------------------------------------------------------------------
  logic [4:0] vindex;
  logic [7:0] lut_addr;
  logic [7:0] lut_data;

  assign vindex   = fourth_monitor_input[`MLC_VINDEX_LSB +: 5];
  assign lut_addr = double_table_mode
                  ? {`MLC_LUT_BASE, upper_table_select, vindex[4:1]}
                  : {`MLC_LUT_BASE, vindex};
  assign lut_data = lut[lut_addr[4:0]];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      fourth_monitor_input_driven_output <= `MLC_RST_FOURTH_MONITOR_INPUT_OUT;
    end else if (conversion_done) begin
      fourth_monitor_input_driven_output <= lut_data;
    end else if (main_hit && wr_ok && !fourth_monitor_input_output_auto_enable
                 && req.addr == `MLC_OFF_FOURTH_MONITOR_INPUT_OUT) begin
      fourth_monitor_input_driven_output <= req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // read path: registered, one cycle after the request
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      reg_rdata  <= `MLC_RD_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= req.rd;
      reg_rdata  <= `MLC_RD_ZERO;
      if (req.rd && main_hit && req.addr == `MLC_OFF_IDENTITY) begin
        reg_rdata <= IDENTITY_VALUE;
      end else if (req.rd && password_level_two && lut_hit) begin
        reg_rdata <= lut[req.addr[4:0]];
      end else if (req.rd && password_level_two && main_hit) begin
        case (req.addr)
          `MLC_OFF_FOURTH_MONITOR_INPUT_OUT: reg_rdata <= fourth_monitor_input_driven_output;
          `MLC_OFF_VERSION:  reg_rdata <= VERSION_VALUE;
          `MLC_OFF_SAMPLE:   reg_rdata <= {4'h0, sample_period_code};
          `MLC_OFF_CONFIG:   reg_rdata <= config_byte;
          `MLC_OFF_DEV_ADDR: reg_rdata <= device_address;
          default:           reg_rdata <= `MLC_RD_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // slave address selection
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      slave_address <= `MLC_DEFAULT_SLAVE;
    end else if (config_byte[`MLC_CFG_ADDRESS_SELECT]) begin
      slave_address <= device_address;
    end else begin
      slave_address <= `MLC_DEFAULT_SLAVE;
    end
  end

  // ----------------------------------------------------------------------
  // apc sample timer
  // ----------------------------------------------------------------------
  mlc_sample_e sample_state;
  logic [10:0] sample_cnt;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sample_state      <= MLC_IDLE;
      sample_cnt        <= 11'h000;
      apc_sample_strobe <= 1'b0;
    end else begin
      apc_sample_strobe <= 1'b0;
      case (sample_state)
        MLC_IDLE: begin
          if (burst_sync) begin
            sample_state <= MLC_FIRST;
            sample_cnt   <= first_cycles(sample_period_code) - 11'h001;
          end
        end
        MLC_FIRST, MLC_REPEAT: begin
          if (!burst_sync) begin
            sample_state <= MLC_IDLE;
          end else if (sample_cnt == 11'h000) begin
            apc_sample_strobe <= 1'b1;
            sample_state      <= MLC_REPEAT;
            sample_cnt        <= rep_cycles(sample_period_code) - 11'h001;
          end else begin
            sample_cnt <= sample_cnt - 11'h001;
          end
        end
        default: sample_state <= MLC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // fault handling
  // ----------------------------------------------------------------------
  logic       supply_ok_seen;
  logic       latch_armed;
  logic       txd_edge;
  logic [7:0] fault_latched;
  logic [7:0] fault_live;
  logic       gate_fault;

  assign txd_edge    = txd_sync ^ txd_prev;
  assign latch_armed = supply_ok_seen
                     || !(alarms.txf_mask[SUPPLY_LOW_BIT] || alarms.gate_mask[SUPPLY_LOW_BIT]);
  assign fault_live  = alarm_sync & (alarms.txf_mask | alarms.gate_mask);
  assign gate_fault  = |(alarm_sync & alarms.gate_mask)
                     || |(fault_latched & alarms.gate_mask);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      supply_ok_seen <= 1'b0;
    end else if (supply_meas_done && supply_above_low) begin
      supply_ok_seen <= 1'b1;
    end
  end

  // a new alarm in the clearing cycle survives the clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      fault_latched <= 8'h00;
    end else if (config_byte[`MLC_CFG_LATCH] && latch_armed) begin
      fault_latched <= (txd_edge ? 8'h00 : fault_latched) | fault_live;
    end else if (!config_byte[`MLC_CFG_LATCH] || txd_edge) begin
      fault_latched <= 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tx_fault_output      <= 1'b0;
      shutdown_gate_output <= 1'b0;
    end else begin
      tx_fault_output <= |(alarm_sync & alarms.txf_mask)
                      || |(fault_latched & alarms.txf_mask);
      shutdown_gate_output <= config_byte[`MLC_CFG_POLARITY] ^ gate_fault;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // cycles since the synchronised burst enable rose, held at its ceiling
  logic [11:0] burst_age;

  always_ff @(posedge clock) begin
    if (!rstn || !burst_sync) begin
      burst_age <= 12'h000;
    end else if (burst_age != 12'hFFF) begin
      burst_age <= burst_age + 12'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  lut_load_a: assert property (conversion_done |=> fourth_monitor_input_driven_output == $past(lut_data))
    else $error("monitor output not loaded from table");
  double_addr_a: assert property (double_table_mode |-> lut_addr[7:4]
      == {`MLC_LUT_BASE, upper_table_select} && lut_addr[3:0] == vindex[4:1])
    else $error("double table address wrong");
  single_addr_a: assert property (!double_table_mode |-> lut_addr
      == {3'b100, fourth_monitor_input[15:11]})
    else $error("single table address wrong");
  fourth_monitor_input_guard_a: assert property (!conversion_done && (fourth_monitor_input_output_auto_enable
      || !password_level_two) |=> $stable(fourth_monitor_input_driven_output))
    else $error("monitor output changed without cause");
  identity_read_a: assert property (req.rd && main_hit && req.addr == 8'h86
      |=> reg_rvalid && reg_rdata == IDENTITY_VALUE)
    else $error("identity read wrong");
  version_read_a: assert property (req.rd && main_hit && req.addr == 8'h87
      |=> reg_rdata == ($past(password_level_two) ? VERSION_VALUE : 8'h00))
    else $error("version read wrong");
  first_sample_a: assert property ($rose(burst_sync) && sample_period_code == 4'h0
      |-> ##71 (apc_sample_strobe || !burst_sync))
    else $error("first sample delay wrong");
  clamp_code_a: assert property (burst_sync && burst_age == 12'h277
      && sample_period_code == 4'hF |-> apc_sample_strobe)
    else $error("clamped code delay wrong");
  sample_read_a: assert property (req.rd && main_hit && password_level_two
      && req.addr == 8'h88 |=> reg_rdata[7:4] == 4'h0)
    else $error("sample register upper bits not zero");
  gate_idle_a: assert property (!gate_fault |=>
      shutdown_gate_output == $past(config_byte[`MLC_CFG_POLARITY]))
    else $error("gate idle level wrong");
  fault_or_a: assert property (|(alarm_sync & alarms.txf_mask) |=> tx_fault_output)
    else $error("fault output missed alarm");
  latch_hold_a: assert property (config_byte[6] && |fault_latched && !txd_edge
      |=> |fault_latched)
    else $error("latched alarm lost");
  latch_wait_a: assert property (!latch_armed && fault_latched == 8'h00
      |=> fault_latched == 8'h00)
    else $error("alarm latched before supply good");
  slave_sel_a: assert property (1'b1 |=> slave_address ==
      ($past(config_byte[4]) ? $past(device_address) : 8'hA2))
    else $error("slave address wrong");

  strobe_seen_c: cover property (apc_sample_strobe ##[1:1000] apc_sample_strobe);
  load_seen_c:   cover property (conversion_done && double_table_mode);
  latch_seen_c:  cover property (|fault_latched ##1 txd_edge);

endmodule : mlc_regs

// *** src/mlc_regs_params.svh ***
// constants of the monitor-four lookup and configuration register bank
// assumes one 200 MHz system clock; included by the register bank only
`ifndef MLC_REGS_PARAMS_SVH
`define MLC_REGS_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets and table selectors
// ----------------------------------------------------------------------
`define MLC_TABLE_MAIN     8'h02
`define MLC_TABLE_LUT      8'h06
`define MLC_OFF_FOURTH_MONITOR_INPUT_OUT   8'h85
`define MLC_OFF_IDENTITY   8'h86
`define MLC_OFF_VERSION    8'h87
`define MLC_OFF_SAMPLE     8'h88
`define MLC_OFF_CONFIG     8'h89
`define MLC_OFF_DEV_ADDR   8'h8C
`define MLC_LUT_BASE       3'h4
`define MLC_RD_ZERO        8'h00

// ----------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------
`define MLC_RST_FOURTH_MONITOR_INPUT_OUT   8'h00
`define MLC_RST_SAMPLE     4'h0
`define MLC_RST_CONFIG     8'h00
`define MLC_RST_DEV_ADDR   8'h00
`define MLC_DEFAULT_SLAVE  8'hA2
`define MLC_CFG_POLARITY   7
`define MLC_CFG_LATCH      6
`define MLC_CFG_ADDRESS_SELECT       4
`define MLC_SAMPLE_LSB     0
`define MLC_SAMPLE_MAX     4'h9
`define MLC_VINDEX_LSB     11

// ----------------------------------------------------------------------
// sample timing, nanoseconds, and clock period
// ----------------------------------------------------------------------
`define MLC_CLOCK_PERIOD_NS 5
`define MLC_FIRST_NS {32'd3150, 32'd2950, 32'd2150, 32'd1750, 32'd1550, \
                      32'd1350, 32'd950, 32'd750, 32'd550, 32'd350}
`define MLC_REP_NS   {32'd6400, 32'd6000, 32'd4400, 32'd3600, 32'd3200, \
                      32'd2800, 32'd2000, 32'd1600, 32'd1200, 32'd800}

`endif

// *** src/mlc_pkg.sv ***
// types of the monitor-four lookup and configuration register bank
// assumes nothing beyond a SystemVerilog compiler
package mlc_pkg;

  // ----------------------------------------------------------------------
  // register access request from the serial front end
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] table_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mlc_req_s;

  // ----------------------------------------------------------------------
  // alarm routing
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] state;
    logic [7:0] txf_mask;
    logic [7:0] gate_mask;
  } mlc_alarm_s;

  typedef enum logic [1:0] {
    MLC_IDLE,
    MLC_FIRST,
    MLC_REPEAT
  } mlc_sample_e;

endpackage : mlc_pkg

// *** sim/mlc_host_model.sv ***
// host-side requester for the lookup and configuration register bank
// assumes the bank's clock; requests change at the falling edge only
`timescale 1ns/100ps

module mlc_host_model
  import mlc_pkg::*;
(
  input  wire logic       clock,
  output mlc_req_s        req,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial req = '{8'h02, 8'h00, 8'h00, 1'b0, 1'b0};

  // ----------------------------------------------------------------------
  // one request per call, fields scrambled once it has been taken
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] tsel, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req = '{tsel, a, d, 1'b1, 1'b0};
    @(negedge clock);
    req = '{~tsel, ~a, ~d, 1'b0, 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] tsel, input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    req = '{tsel, a, ~a, 1'b0, 1'b1};
    @(negedge clock);
    req = '{~tsel, ~a, a, 1'b0, 1'b0};
    // the answer must stand exactly one cycle after the request
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : mlc_host_model

// *** sim/tb.sv ***
// self-checking bench of the lookup and configuration register bank
// assumes the host model drives the request port; inputs move at falling edges
`timescale 1ns/100ps

module tb;
  import mlc_pkg::*;
  localparam logic [7:0] ID_V  = 8'h3C;  // arbitrary value
  localparam logic [7:0] VER_V = 8'h07;  // arbitrary value
  localparam int FT [10] = '{70, 110, 150, 190, 270, 310, 350, 430, 590, 630};
  localparam int RP [10] = '{160, 240, 320, 400, 560, 640, 720, 880, 1200, 1280};
  logic        clock, rstn, pw, auto_en, dbl, upper, conv, smd, sabove, burst, txd;
  logic [15:0] mon;
  mlc_alarm_s  alarms;
  mlc_req_s    req;
  logic [7:0]  rdata, m4o, saddr, d;
  logic        rvalid, strobe, gate, txf;
  int          fail_count, samples_checked, cyc;

  mlc_host_model i_host (.clock(clock), .req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  mlc_regs #(.IDENTITY_VALUE(ID_V), .VERSION_VALUE(VER_V)) i_dut (
    .clock(clock), .rstn(rstn), .req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .password_level_two(pw), .fourth_monitor_input_output_auto_enable(auto_en),
    .double_table_mode(dbl), .upper_table_select(upper), .conversion_done(conv),
    .fourth_monitor_input(mon), .supply_meas_done(smd), .supply_above_low(sabove),
    .alarms(alarms), .burst_enable_input(burst), .tx_disable_input(txd),
    .fourth_monitor_input_driven_output(m4o), .apc_sample_strobe(strobe), .shutdown_gate_output(gate),
    .tx_fault_output(txf), .slave_address(saddr));

  // ----------------------------------------------------------------------
  // clock, watchdog, reporting
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wcyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wcyc

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    i_host.rd(8'h02, a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask : rdchk

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    rdchk("rate_rst", 8'h88, 8'h00);
    rdchk("cfg_rst", 8'h89, 8'h00);
    chk("slave_rst", 16'h00A2, {8'h00, saddr});
    chk("gate_rst", 16'h0000, {15'h0, gate});
  endtask : t_reset

  task automatic t_fault;
    alarms = '{8'h00, 8'h03, 8'h03};
    i_host.wr(8'h02, 8'h89, 8'h40);
    alarms.state = 8'h04;
    wcyc(5);
    chk("txf_unmasked", 16'h0, {15'h0, txf});
    alarms.state = 8'h01;
    wcyc(5);
    chk("txf_on", 16'h1, {15'h0, txf});
    chk("gate_fault", 16'h1, {15'h0, gate});
    alarms.state = 8'h00;
    wcyc(5);
    chk("txf_no_latch_early", 16'h0, {15'h0, txf});
    smd = 1'b1;
    sabove = 1'b1;
    wcyc(1);
    smd = 1'b0;
    alarms.state = 8'h01;
    wcyc(5);
    alarms.state = 8'h00;
    wcyc(5);
    chk("txf_latched", 16'h1, {15'h0, txf});
    txd = 1'b1;
    wcyc(6);
    chk("txf_cleared", 16'h0, {15'h0, txf});
    i_host.wr(8'h02, 8'h89, 8'h00);
    alarms.state = 8'h02;
    wcyc(5);
    alarms.state = 8'h00;
    wcyc(5);
    chk("txf_live", 16'h0, {15'h0, txf});
    i_host.wr(8'h02, 8'h89, 8'h80);
    wcyc(3);
    chk("gate_pol1", 16'h1, {15'h0, gate});
    alarms.state = 8'h02;
    wcyc(5);
    chk("gate_pol1_fault", 16'h0, {15'h0, gate});
    alarms.state = 8'h00;
    i_host.wr(8'h02, 8'h89, 8'h00);
  endtask : t_fault

  task automatic t_regs;
    pw = 1'b0;
    i_host.wr(8'h02, 8'h89, 8'hFF);
    rdchk("id_nopw", 8'h86, ID_V);
    rdchk("ver_nopw", 8'h87, 8'h00);
    pw = 1'b1;
    rdchk("cfg_nopw_wr", 8'h89, 8'h00);
    i_host.wr(8'h02, 8'h86, ~ID_V);
    i_host.wr(8'h02, 8'h87, ~VER_V);
    rdchk("id", 8'h86, ID_V);
    rdchk("ver", 8'h87, VER_V);
    i_host.wr(8'h02, 8'h88, 8'hFF);
    rdchk("rate_bits", 8'h88, 8'h0F);
    i_host.wr(8'h02, 8'h8C, 8'h5E);
    i_host.wr(8'h02, 8'h89, 8'hFF);
    rdchk("cfg_bits", 8'h89, 8'hD0);
    chk("slave_prog", 16'h005E, {8'h00, saddr});
    i_host.wr(8'h02, 8'h89, 8'h00);
    wcyc(2);
    chk("slave_def", 16'h00A2, {8'h00, saddr});
  endtask : t_regs

  task automatic t_lut;
    logic [7:0] a;
    logic [4:0] ix [3] = '{5'h00, 5'h13, 5'h1F};
    for (int k = 0; k < 32; k++) begin
      a = 8'h80 + 8'(k);
      i_host.wr(8'h06, a, {a[3:0], a[7:4]} ^ 8'h5A);
    end
    auto_en = 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int j = 0; j < 3; j++) begin
        dbl = (m != 0);
        upper = (m == 2);
        @(negedge clock);
        mon = {ix[j], 11'h5A5};
        conv = 1'b1;
        @(negedge clock);
        conv = 1'b0;
        mon = ~mon;
        wcyc(1);
        a = dbl ? {3'b100, upper, ix[j][4:1]} : {3'b100, ix[j]};
        chk("m4_out", {8'h00, {a[3:0], a[7:4]} ^ 8'h5A}, {8'h00, m4o});
        rdchk("m4_reg", 8'h85, {a[3:0], a[7:4]} ^ 8'h5A);
      end
    end
    auto_en = 1'b0;
    i_host.wr(8'h02, 8'h85, 8'hA7);
    rdchk("m4_wr", 8'h85, 8'hA7);
    auto_en = 1'b1;
    i_host.wr(8'h02, 8'h85, 8'h3C);
    auto_en = 1'b0;
    pw = 1'b0;
    i_host.wr(8'h02, 8'h85, 8'h3C);
    rdchk("m4_rd_nopw", 8'h85, 8'h00);
    pw = 1'b1;
    rdchk("m4_wr_refused", 8'h85, 8'hA7);
  endtask : t_lut

  task automatic t_sample;
    int n;
    int k;
    for (int c = 0; c < 16; c++) begin
      k = (c > 9) ? 9 : c;
      i_host.wr(8'h02, 8'h88, 8'(c));
      @(negedge clock);
      burst = 1'b1;
      n = 0;
      while (strobe !== 1'b1 && n < 2000) begin
        @(negedge clock);
        n++;
      end
      chk("first_ok", 16'h1, {15'h0, (n >= FT[k] - 10 && n <= FT[k] + 10)});
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (strobe !== 1'b1 && n < 2000);
      chk("repeat", 16'(RP[k]), 16'(n));
      burst = 1'b0;
      wcyc(4);
    end
    n = 0;
    repeat (1400) begin
      @(negedge clock);
      if (strobe === 1'b1) n++;
    end
    chk("stopped", 16'h0, 16'(n));
  endtask : t_sample

  initial begin
    rstn = 1'b0;
    pw = 1'b1;
    auto_en = 1'b0;
    dbl = 1'b0;
    upper = 1'b0;
    conv = 1'b0;
    smd = 1'b0;
    sabove = 1'b0;
    burst = 1'b0;
    txd = 1'b0;
    mon = 16'h0000;
    alarms = '{8'h00, 8'h00, 8'h00};
    fail_count = 0;
    samples_checked = 0;
    cyc = 0;
    wcyc(6);
    rstn = 1'b1;
    t_reset();
    t_fault();
    t_regs();
    t_lut();
    t_sample();
    end_of_test();
  end
endmodule : tb
